//--- logic/fgc_regs.vh
// Register map, fields and timing of the flash host controller
`ifndef FGC_REGS_VH
`define FGC_REGS_VH
`define FGC_CTRL_OFS     8'h00
`define FGC_ADDR_OFS     8'h04
`define FGC_WDATA_OFS    8'h08
`define FGC_STATUS_OFS   8'h0C
`define FGC_RDATA_OFS    8'h10
`define FGC_PCNT_OFS     8'h14
`define FGC_OP_WRITE     3'h0
`define FGC_OP_READ      3'h1
`define FGC_OP_STATREAD  3'h2
`define FGC_OP_POLL      3'h3
`define FGC_OP_HWRST     3'h4
`define FGC_ST_BUSY      0
`define FGC_ST_DONE      1
`define FGC_ST_READY     2
`define FGC_ST_REFUSED   3
`define FGC_TOGGLE_BIT   6
`define FGC_SECT_LSB     16
`define FGC_CLK_NS       25
`define FGC_T_WP_NS      35
`define FGC_T_ACC_NS     70
`define FGC_T_REC_NS     35
`define FGC_T_RP_NS      200
`define FGC_T_RH_NS      50
`define FGC_T_POR_US     300
`define FGC_CEIL(t)      (((t) + `FGC_CLK_NS - 1) / `FGC_CLK_NS)
`define FGC_WP_CYC       `FGC_CEIL(`FGC_T_WP_NS)
`define FGC_ACC_CYC      `FGC_CEIL(`FGC_T_ACC_NS)
`define FGC_REC_CYC      `FGC_CEIL(`FGC_T_REC_NS)
`define FGC_RP_CYC       `FGC_CEIL(`FGC_T_RP_NS)
`define FGC_RH_CYC       `FGC_CEIL(`FGC_T_RH_NS)
`define FGC_POR_CYC      `FGC_CEIL(`FGC_T_POR_US * 1000)
`endif

//--- logic/fgc_cycle.v
// One asynchronous flash read or write cycle on the pins
`timescale 1ns/100ps
`include "fgc_regs.vh"
module fgc_cycle #(
  parameter AW = 26,
  parameter DW = 16
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          start,
  input  wire          wr,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg           done_r,
  output reg  [DW-1:0] rdata_r,
  output reg  [AW-1:0] fl_addr_r,
  output reg  [DW-1:0] fl_dq_out_r,
  output reg           fl_dq_oe_r,
  input  wire [DW-1:0] fl_dq_in,
  output reg           fl_ce_n_r,
  output reg           fl_we_n_r,
  output reg           fl_oe_n_r
);
  localparam CY_IDLE = 2'd0;
  localparam CY_ACT  = 2'd1;
  localparam CY_HOLD = 2'd2;
  // Two extra cycles cover the data synchroniser
  localparam integer RD_CYC = `FGC_ACC_CYC + 2;
  localparam integer WP_CYC = `FGC_WP_CYC;
  localparam integer RC_CYC = `FGC_REC_CYC;

  reg [1:0]    st_r;
  reg          wr_r;
  reg [31:0]   cnt_r;
  reg [DW-1:0] dq_s1_r;
  reg [DW-1:0] dq_s2_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= CY_IDLE;
      wr_r        <= 1'b0;
      cnt_r       <= 32'h0;
      dq_s1_r     <= {DW{1'b0}};
      dq_s2_r     <= {DW{1'b0}};
      done_r      <= 1'b0;
      rdata_r     <= {DW{1'b0}};
      fl_addr_r   <= {AW{1'b0}};
      fl_dq_out_r <= {DW{1'b0}};
      fl_dq_oe_r  <= 1'b0;
      fl_ce_n_r   <= 1'b1;
      fl_we_n_r   <= 1'b1;
      fl_oe_n_r   <= 1'b1;
    end else begin
      done_r  <= 1'b0;
      dq_s1_r <= fl_dq_in;
      dq_s2_r <= dq_s1_r;
      case (st_r)
        CY_IDLE: begin
          if (start) begin
            wr_r      <= wr;
            fl_addr_r <= addr;
            fl_ce_n_r <= 1'b0;
            cnt_r     <= 32'h0;
            st_r      <= CY_ACT;
            if (wr) begin
              fl_dq_out_r <= wdata;
              fl_dq_oe_r  <= 1'b1;
              fl_we_n_r   <= 1'b0;
            end else begin
              fl_oe_n_r <= 1'b0;
            end
          end
        end
        CY_ACT: begin
          cnt_r <= cnt_r + 32'h1;
          if (wr_r && cnt_r == WP_CYC - 1) begin
            fl_we_n_r <= 1'b1;
            cnt_r     <= 32'h0;
            st_r      <= CY_HOLD;
          end else if (!wr_r && cnt_r == RD_CYC - 1) begin
            rdata_r   <= dq_s2_r;
            fl_oe_n_r <= 1'b1;
            fl_ce_n_r <= 1'b1;
            cnt_r     <= 32'h0;
            st_r      <= CY_HOLD;
          end
        end
        CY_HOLD: begin
          // Data held one cycle past the write strobe rise
          fl_ce_n_r  <= 1'b1;
          fl_dq_oe_r <= 1'b0;
          cnt_r      <= cnt_r + 32'h1;
          if (cnt_r == RC_CYC - 1) begin
            done_r <= 1'b1;
            st_r   <= CY_IDLE;
          end
        end
        default: st_r <= CY_IDLE;
      endcase
    end
  end
endmodule

//--- logic/fgc_host.v
// Host-side flash controller: APB registers and command sequencer
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "fgc_regs.vh"
// How it works
// - Status word is read only at word location 0 of the sector.
// - Lock word is read or programmed by software at location 0.
// - Host holds chip, write and output enables high through power-up.
// - Host recovers unknown state by reset command or reset pin pulse.
module fgc_host #(
  parameter AW      = 26,
  parameter DW      = 16,
  parameter POR_CYC = `FGC_POR_CYC
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata_r,
  output reg           pready_r,
  output reg           pslverr_r,
  output wire [AW-1:0] fl_addr,
  output wire [DW-1:0] fl_dq_out,
  output wire          fl_dq_oe,
  input  wire [DW-1:0] fl_dq_in,
  output wire          fl_ce_n,
  output wire          fl_we_n,
  output wire          fl_oe_n,
  output reg           fl_reset_n_r
);
  localparam M_POR  = 3'd0;
  localparam M_IDLE = 3'd1;
  localparam M_C1   = 3'd2;
  localparam M_C2   = 3'd3;
  localparam M_RSTP = 3'd4;
  localparam M_RSTW = 3'd5;
  localparam integer RP_CYC = `FGC_RP_CYC;
  localparam integer RH_CYC = `FGC_RH_CYC;

  reg [2:0]    st_r;
  reg [2:0]    op_r;
  reg [31:0]   cnt_r;
  reg [AW-1:0] addr_r;
  reg [DW-1:0] wdata_r;
  reg [DW-1:0] rdata_r;
  reg [DW-1:0] prev_r;
  reg [15:0]   pcnt_r;
  reg          done_r;
  reg          refused_r;
  reg          por_done_r;
  reg          cyc_start_r;
  reg          cyc_wr_r;
  reg [AW-1:0] cyc_addr_r;
  reg [DW-1:0] cyc_wdata_r;
  wire         cyc_done;
  wire [DW-1:0] cyc_rdata;

  // Register index from byte address; 7 means unmapped
  function [2:0] reg_idx;
    input [7:0] a;
    begin
      case (a)
        `FGC_CTRL_OFS:   reg_idx = 3'd0;
        `FGC_ADDR_OFS:   reg_idx = 3'd1;
        `FGC_WDATA_OFS:  reg_idx = 3'd2;
        `FGC_STATUS_OFS: reg_idx = 3'd3;
        `FGC_RDATA_OFS:  reg_idx = 3'd4;
        `FGC_PCNT_OFS:   reg_idx = 3'd5;
        default:         reg_idx = 3'd7;
      endcase
    end
  endfunction

  wire       setup_ph = psel && !penable;
  wire       wr_acc   = psel && penable && pready_r && pwrite;
  wire [2:0] wr_idx   = reg_idx(paddr);
  wire       busy     = (st_r != M_IDLE);
  wire       ctrl_wr  = wr_acc && wr_idx == 3'd0;
  // word 0 of the sector named by the upper bits
  wire [AW-1:0] sect_base = {addr_r[AW-1:`FGC_SECT_LSB],
                             {`FGC_SECT_LSB{1'b0}}};
  wire       finish   = cyc_done && (st_r == M_C1 || st_r == M_C2) &&
                        !(st_r == M_C1 &&
                          (op_r == `FGC_OP_STATREAD ||
                           op_r == `FGC_OP_POLL)) &&
                        !(st_r == M_C2 && op_r == `FGC_OP_POLL &&
                          cyc_rdata[`FGC_TOGGLE_BIT] !=
                          prev_r[`FGC_TOGGLE_BIT]);
  wire       rst_end  = (st_r == M_RSTW) && (cnt_r == RH_CYC - 1);

  // APB slave: zero wait states, data registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (setup_ph) begin
        pslverr_r <= (wr_idx == 3'd7);
        case (wr_idx)
          3'd0: prdata_r <= {29'h0, op_r};
          3'd1: prdata_r <= {{(32-AW){1'b0}}, addr_r};
          3'd2: prdata_r <= {{(32-DW){1'b0}}, wdata_r};
          3'd3: prdata_r <= {28'h0, refused_r, por_done_r, done_r, busy};
          3'd4: prdata_r <= {{(32-DW){1'b0}}, rdata_r};
          3'd5: prdata_r <= {16'h0, pcnt_r};
          default: prdata_r <= 32'h0;
        endcase
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r    <= 1'b0;
      refused_r <= 1'b0;
      addr_r    <= {AW{1'b0}};
      wdata_r   <= {DW{1'b0}};
    end else begin
      if (wr_acc && wr_idx == 3'd1 && !busy)
        addr_r <= pwdata[AW-1:0];
      if (wr_acc && wr_idx == 3'd2 && !busy)
        wdata_r <= pwdata[DW-1:0];
      if (finish || rst_end)
        done_r <= 1'b1;
      else if (wr_acc && wr_idx == 3'd3 && pwdata[`FGC_ST_DONE])
        done_r <= 1'b0;
      if (ctrl_wr && busy)
        refused_r <= 1'b1;
      else if (wr_acc && wr_idx == 3'd3 && pwdata[`FGC_ST_REFUSED])
        refused_r <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r         <= M_POR;
      op_r         <= `FGC_OP_WRITE;
      cnt_r        <= 32'h0;
      rdata_r      <= {DW{1'b0}};
      prev_r       <= {DW{1'b0}};
      pcnt_r       <= 16'h0;
      por_done_r   <= 1'b0;
      cyc_start_r  <= 1'b0;
      cyc_wr_r     <= 1'b0;
      cyc_addr_r   <= {AW{1'b0}};
      cyc_wdata_r  <= {DW{1'b0}};
      fl_reset_n_r <= 1'b1;
    end else begin
      cyc_start_r <= 1'b0;
      case (st_r)
        // strobes stay high until power-up time ends
        M_POR: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r == POR_CYC - 1) begin
            por_done_r <= 1'b1;
            st_r       <= M_IDLE;
          end
        end
        M_IDLE: begin
          if (ctrl_wr) begin
            op_r        <= pwdata[2:0];
            cyc_addr_r  <= addr_r;
            cyc_wdata_r <= wdata_r;
            cnt_r       <= 32'h0;
            case (pwdata[2:0])
              `FGC_OP_WRITE, `FGC_OP_STATREAD: begin
                cyc_wr_r    <= 1'b1;
                cyc_start_r <= 1'b1;
                st_r        <= M_C1;
              end
              `FGC_OP_READ, `FGC_OP_POLL: begin
                cyc_wr_r    <= 1'b0;
                cyc_start_r <= 1'b1;
                pcnt_r      <= 16'h0;
                st_r        <= M_C1;
              end
              // hardware reset pulse recovers the device
              `FGC_OP_HWRST: begin
                fl_reset_n_r <= 1'b0;
                st_r         <= M_RSTP;
              end
              default: st_r <= M_IDLE;
            endcase
          end
        end
        M_C1: begin
          if (cyc_done) begin
            rdata_r <= cyc_rdata;
            prev_r  <= cyc_rdata;
            pcnt_r  <= pcnt_r + 16'h1;
            if (op_r == `FGC_OP_STATREAD) begin
              // status is read at word 0 only
              // this one read leaves the overlay
              cyc_wr_r    <= 1'b0;
              cyc_addr_r  <= sect_base;
              cyc_start_r <= 1'b1;
              st_r        <= M_C2;
            end else if (op_r == `FGC_OP_POLL) begin
              cyc_start_r <= 1'b1;
              st_r        <= M_C2;
            end else begin
              st_r <= M_IDLE;
            end
          end
        end
        M_C2: begin
          if (cyc_done) begin
            rdata_r <= cyc_rdata;
            prev_r  <= cyc_rdata;
            pcnt_r  <= pcnt_r + 16'h1;
            // toggling stops once the algorithm completes
            if (finish)
              st_r <= M_IDLE;
            else
              cyc_start_r <= 1'b1;
          end
        end
        M_RSTP: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r == RP_CYC - 1) begin
            fl_reset_n_r <= 1'b1;
            cnt_r        <= 32'h0;
            st_r         <= M_RSTW;
          end
        end
        M_RSTW: begin
          cnt_r <= cnt_r + 32'h1;
          if (rst_end)
            st_r <= M_IDLE;
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end

  fgc_cycle #(
    .AW (AW),
    .DW (DW)
  ) u_cycle (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (cyc_start_r),
    .wr          (cyc_wr_r),
    .addr        (cyc_addr_r),
    .wdata       (cyc_wdata_r),
    .done_r      (cyc_done),
    .rdata_r     (cyc_rdata),
    .fl_addr_r   (fl_addr),
    .fl_dq_out_r (fl_dq_out),
    .fl_dq_oe_r  (fl_dq_oe),
    .fl_dq_in    (fl_dq_in),
    .fl_ce_n_r   (fl_ce_n),
    .fl_we_n_r   (fl_we_n),
    .fl_oe_n_r   (fl_oe_n)
  );
endmodule

//--- tb/fgc_host_chk.sv
// Port assertions for the flash host controller
`timescale 1ns/100ps
module fgc_host_chk #(
  parameter POR_CYC = 20
) (
  input wire       pclk,
  input wire       presetn,
  input wire       psel,
  input wire       penable,
  input wire [7:0] paddr,
  input wire       pready_r,
  input wire       pslverr_r,
  input wire       fl_dq_oe,
  input wire       fl_ce_n,
  input wire       fl_we_n,
  input wire       fl_oe_n,
  input wire       fl_reset_n_r
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_we_pulse;
    !fl_we_n [*2] ##1 fl_we_n;
  endsequence
  sequence s_rd_pulse;
    !fl_oe_n [*5] ##1 fl_oe_n;
  endsequence
  sequence s_rst_pulse;
    !fl_reset_n_r [*8] ##1 fl_reset_n_r;
  endsequence
  a_strobes_idle_por: assert property (
    $rose(presetn) |-> (fl_ce_n && fl_we_n && fl_oe_n) [*8])
    else $error("strobes active right after reset");
  a_rst_pin_pulse: assert property (
    $fell(fl_reset_n_r) |-> s_rst_pulse)
    else $error("reset pin pulse length wrong");
  a_we_pulse_len: assert property ($fell(fl_we_n) |-> s_we_pulse)
    else $error("write strobe length wrong");
  a_rd_pulse_len: assert property ($fell(fl_oe_n) |-> s_rd_pulse)
    else $error("read strobe length wrong");
  a_strobe_needs_ce: assert property (!fl_we_n || !fl_oe_n |-> !fl_ce_n)
    else $error("strobe without chip enable");
  a_no_bus_fight: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n)
    else $error("host drives data during read");
  a_apb_zero_wait: assert property (psel && penable |-> pready_r)
    else $error("access phase without ready");
  a_unmapped_err: assert property (
    psel && penable && paddr > 8'h14 |-> pslverr_r)
    else $error("unmapped access not flagged");
endmodule
bind fgc_host fgc_host_chk #(.POR_CYC(POR_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready_r(pready_r), .pslverr_r(pslverr_r),
  .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
  .fl_oe_n(fl_oe_n), .fl_reset_n_r(fl_reset_n_r));

//--- tb/fgc_flash_model.sv
// Behavioural flash device facing the host controller
`timescale 1ns/100ps
module fgc_flash_model #(
  parameter        POR_NS = 800,
  parameter        TOG    = 4,
  parameter [15:0] STATW  = 16'h0080,
  parameter [15:0] C_STAT = 16'h0070,
  parameter [15:0] C_PROG = 16'h00A0,
  parameter [15:0] C_RST  = 16'h00F0
) (
  input  wire [25:0] fl_addr,
  input  wire [15:0] fl_dq_out,
  input  wire        fl_dq_oe,
  output wire [15:0] fl_dq_in,
  input  wire        fl_ce_n,
  input  wire        fl_we_n,
  input  wire        fl_oe_n,
  input  wire        fl_reset_n
);
  logic [1:0]  mode = 2'h0;
  logic        pend = 1'b0;
  logic        por_ok = 1'b0;
  logic        tog = 1'b1;
  logic        we_q = 1'b1;
  logic        oe_q = 1'b1;
  logic        pv_ok = 1'b0;
  logic [15:0] pval = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [15:0] word;
  logic [25:0] padr = 26'h0;
  logic [25:0] rd_adr = 26'h0;
  int          cnt = 0;
  // deaf to all pins until power-up ends
  initial #(POR_NS) por_ok = 1'b1;
  // one map, overlay word at every address
  always @* begin
    if (mode == 2'h1) word = STATW;
    else if (mode == 2'h2) word = {9'h0, tog, 6'h0};
    else if (pv_ok && fl_addr == padr) word = pval;
    else word = fl_addr[15:0] ^ 16'hC3C3;
  end
  // command writes never reach the read path
  // inverse of last word when not read, so stale data shows
  assign fl_dq_in = (por_ok && !fl_ce_n && !fl_oe_n) ? word : ~last;
  always @(fl_we_n or fl_oe_n or fl_reset_n) begin
    // reset pin returns controller to standby
    if (!fl_reset_n && por_ok) begin
      mode = 2'h0;
      pend = 1'b0;
    end else if (por_ok && !fl_ce_n && fl_we_n && !we_q) begin
      // algorithm only after the full sequence
      if (fl_dq_out == C_RST) begin
        mode = 2'h0;
        pend = 1'b0;
      end else if (pend) begin
        pval = fl_dq_out;
        padr = fl_addr;
        pv_ok = 1'b1;
        pend = 1'b0;
        mode = 2'h2;
        tog = 1'b1;
        cnt = TOG;
      end else if (fl_dq_out == C_STAT) mode = 2'h1;
      else pend = (fl_dq_out == C_PROG);
    end else if (por_ok && fl_oe_n && !oe_q) begin
      last = word;
      rd_adr = fl_addr;
      if (mode == 2'h1) mode = 2'h0;
      else if (mode == 2'h2) begin
        tog = !tog;
        cnt = cnt - 1;
        if (cnt == 0) mode = 2'h0;
      end
    end
    we_q = fl_we_n;
    oe_q = fl_oe_n;
  end
endmodule

//--- tb/fgc_host_test.sv
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
`include "fgc_regs.vh"
module fgc_host_test;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, dq_oe, ce_n, we_n, oe_n, rst_n;
  wire  [25:0] fl_addr;
  wire  [15:0] dq_out, dq_in;
  logic [31:0] q;
  logic        e;
  int          error_cnt = 0;
  int          total_checks = 0;
  always #12.5 pclk = ~pclk;
  fgc_host #(.POR_CYC(20)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata),
    .pready_r(pready), .pslverr_r(pslverr), .fl_addr(fl_addr),
    .fl_dq_out(dq_out), .fl_dq_oe(dq_oe), .fl_dq_in(dq_in),
    .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n), .fl_reset_n_r(rst_n));
  fgc_flash_model i_flash (
    .fl_addr(fl_addr), .fl_dq_out(dq_out), .fl_dq_oe(dq_oe),
    .fl_dq_in(dq_in), .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n),
    .fl_reset_n(rst_n));
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; holds everything until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done();
    q = 32'h0;
    for (int i = 0; i < 300 && q[1] !== 1'b1; i++)
      apb(1'b0, `FGC_STATUS_OFS, 32'h0);
    // Running out of polls counts as a mismatch
    chk("op done", {31'h0, q[1]}, 32'h1);
    apb(1'b1, `FGC_STATUS_OFS, 32'h2);
  endtask
  task automatic run_op(input logic [2:0] op, input logic [25:0] a,
                        input logic [15:0] d);
    apb(1'b1, `FGC_ADDR_OFS, {6'h0, a});
    apb(1'b1, `FGC_WDATA_OFS, {16'h0, d});
    apb(1'b1, `FGC_CTRL_OFS, {29'h0, op});
    wait_done();
  endtask
  task automatic t_por();
    apb(1'b1, `FGC_CTRL_OFS, 32'h1);
    apb(1'b0, `FGC_STATUS_OFS, 32'h0);
    // Busy through power-up; early op write is flagged refused
    chk("status in power-up", q, 32'h9);
    for (int i = 0; i < 100 && q[2] !== 1'b1; i++)
      apb(1'b0, `FGC_STATUS_OFS, 32'h0);
    chk("ready bit", {31'h0, q[2]}, 32'h1);
    apb(1'b1, `FGC_STATUS_OFS, 32'h8);
    apb(1'b0, `FGC_STATUS_OFS, 32'h0);
    chk("power-up refused cleared", q, 32'h4);
    $display("end of t_por");
  endtask
  task automatic t_unmapped();
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped read err", {31'h0, e}, 32'h1);
    chk("unmapped read data", q, 32'h0);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk("unmapped write err", {31'h0, e}, 32'h1);
    $display("end of t_unmapped");
  endtask
  task automatic t_status();
    run_op(`FGC_OP_READ, 26'h0012345, 16'h0);
    apb(1'b0, `FGC_RDATA_OFS, 32'h0);
    chk("array word", q, {16'h0, 16'h2345 ^ 16'hC3C3});
    run_op(`FGC_OP_STATREAD, 26'h0035678, 16'h0070);
    apb(1'b0, `FGC_RDATA_OFS, 32'h0);
    chk("status word", q, 32'h0080);
    chk("status addr", {6'h0, i_flash.rd_adr}, 32'h0030000);
    run_op(`FGC_OP_READ, 26'h0035678, 16'h0);
    apb(1'b0, `FGC_RDATA_OFS, 32'h0);
    chk("array after status", q, {16'h0, 16'h5678 ^ 16'hC3C3});
    $display("end of t_status");
  endtask
  task automatic t_prog();
    run_op(`FGC_OP_WRITE, 26'h0000555, 16'h00A0);
    run_op(`FGC_OP_WRITE, 26'h0000042, 16'h1234);
    apb(1'b1, `FGC_CTRL_OFS, {29'h0, `FGC_OP_POLL});
    apb(1'b1, `FGC_CTRL_OFS, {29'h0, `FGC_OP_READ});
    // Address writes while busy must be dropped
    apb(1'b1, `FGC_ADDR_OFS, 32'h77);
    wait_done();
    apb(1'b0, `FGC_ADDR_OFS, 32'h0);
    chk("addr kept while busy", q, 32'h42);
    apb(1'b0, `FGC_STATUS_OFS, 32'h0);
    chk("refused flag", {31'h0, q[3]}, 32'h1);
    apb(1'b0, `FGC_RDATA_OFS, 32'h0);
    chk("programmed word", q, 32'h1234);
    apb(1'b0, `FGC_PCNT_OFS, 32'h0);
    chk("poll reads", q, 32'h5);
    apb(1'b1, `FGC_STATUS_OFS, 32'h8);
    apb(1'b0, `FGC_STATUS_OFS, 32'h0);
    chk("refused cleared", {31'h0, q[3]}, 32'h0);
    $display("end of t_prog");
  endtask
  task automatic t_hwrst();
    run_op(`FGC_OP_WRITE, 26'h0000555, 16'h00A0);
    run_op(`FGC_OP_HWRST, 26'h0, 16'h0);
    chk("sequence dropped", {31'h0, i_flash.pend}, 32'h0);
    apb(1'b1, `FGC_CTRL_OFS, 32'h5);
    apb(1'b0, `FGC_STATUS_OFS, 32'h0);
    chk("op 5 ignored", q, 32'h4);
    $display("end of t_hwrst");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_por();
    t_unmapped();
    t_status();
    t_prog();
    t_hwrst();
    give_verdict();
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end
endmodule
